/* logic/mic_irq_ctrl.sv */
// Contract
// - Master enable bit0 gates all vectoring.
// - Timer1, timer0, pin flags at bits 6,5,4.
// - Timer1, timer0, pin enables at bits 3,2,1.
// - Second register: combined/tick flags and enables.
// - Op-amp and comparator flags, enables in third.
// - Unimplemented bits read back as zero.
// - Timer overflow sets flag; vector needs enables.
// - Timer service clears its flag and master.
// - Tick overflow sets flag; vector needs enables.
// - Tick service clears its flag and master.
// - Enabled op-amp fall or comparator change sets combined.
// - Combined source vectors to address 18H.
// - Combined service clears it; sub-flags remain.
// - Flags stay until serviced or written zero.
// - No acknowledge while the stack is full.
// - Every source can wake the core.
// - Entry pushes only the program counter.
// - Vectors 08H, 0CH, 14H for timers, tick.
// - Fixed priority pin, t0, t1, tick, combined.
// - Two-bit edge select for the pin.
// - Vector after 2 cycles, 3 from low power.
`timescale 1ns/1ps
`default_nettype none
`include "mic_consts.svh"

module mic_irq_ctrl (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_we,
    input wire logic bus_re,
    output logic [7:0] bus_rdata,
    input wire logic pin_irq_in,
    input wire logic timer0_ovf,
    input wire logic timer1_ovf,
    input wire logic tick_ovf,
    input wire logic opamp0_out,
    input wire logic opamp1_out,
    input wire logic comparator_out,
    input wire logic stack_full,
    input wire logic low_power,
    output logic vec_call,
    output logic pc_push,
    output logic [11:0] vec_addr,
    output logic wake_req
);

    mic_pkg::mic_state_s s_reg;
    mic_pkg::mic_state_s s_next;
    logic instr_en;
    logic [3:0] async_in;
    logic [4:0] pend;
    logic pin_ev;
    logic op0_ev;
    logic op1_ev;
    logic cmp_ev;
    logic wr_c0;
    logic wr_c1;
    logic wr_mf;
    logic [11:0] fire_vec;

    function automatic logic edge_hit(input logic was, input logic now, input logic [1:0] sel);
        logic hit;
        hit = 1'b0;
        case (sel)
            `MIC_EDGE_RISE: hit = !was && now;
            `MIC_EDGE_FALL: hit = was && !now;
            `MIC_EDGE_BOTH: hit = was ^ now;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    // Lowest index wins, so the pin always outranks the combined source.
    function automatic logic [11:0] pick_vec(input logic [4:0] p);
        logic [11:0] v;
        v = `MIC_VEC_NONE;
        if (p[0]) begin
            v = `MIC_VEC_PIN;
        end else if (p[1]) begin
            v = `MIC_VEC_T0;
        end else if (p[2]) begin
            v = `MIC_VEC_T1;
        end else if (p[3]) begin
            v = `MIC_VEC_TICK;
        end else if (p[4]) begin
            v = `MIC_VEC_MF;
        end
        return v;
    endfunction

    assign async_in = {comparator_out, opamp1_out, opamp0_out, pin_irq_in};
    assign bus_rdata = s_reg.rdata;
    assign vec_call = s_reg.core.vec_call;
    assign pc_push = s_reg.core.pc_push;
    assign vec_addr = s_reg.core.vec_addr;
    assign wake_req = s_reg.core.wake;

    always_comb begin
        s_next = s_reg;
        // Pins are sampled twice before any edge logic sees them.
        s_next.sync1 = async_in;
        s_next.sync2 = s_reg.sync1;
        s_next.prev = s_reg.sync2;
        s_next.rdata = 8'h00;
        s_next.core.vec_call = 1'b0;
        s_next.core.pc_push = 1'b0;
        // One instruction cycle is four system clocks.
        s_next.div = s_reg.div + 2'h1;
        instr_en = (s_reg.div == `MIC_DIV_LAST);

        pin_ev = edge_hit(s_reg.prev[`MIC_IN_PIN], s_reg.sync2[`MIC_IN_PIN],
                          s_reg.esel[1:0]);
        op0_ev = edge_hit(s_reg.prev[`MIC_IN_OP0], s_reg.sync2[`MIC_IN_OP0],
                          `MIC_EDGE_FALL);
        op1_ev = edge_hit(s_reg.prev[`MIC_IN_OP1], s_reg.sync2[`MIC_IN_OP1],
                          `MIC_EDGE_FALL);
        cmp_ev = edge_hit(s_reg.prev[`MIC_IN_CMP], s_reg.sync2[`MIC_IN_CMP],
                          `MIC_EDGE_BOTH);

        pend[0] = s_reg.c0[`MIC_C0_PINF] && s_reg.c0[`MIC_C0_PINE];
        pend[1] = s_reg.c0[`MIC_C0_T0F] && s_reg.c0[`MIC_C0_T0E];
        pend[2] = s_reg.c0[`MIC_C0_T1F] && s_reg.c0[`MIC_C0_T1E];
        pend[3] = s_reg.c1[`MIC_C1_TBF] && s_reg.c1[`MIC_C1_TBE];
        pend[4] = s_reg.c1[`MIC_C1_MFF] && s_reg.c1[`MIC_C1_MFE];
        fire_vec = pick_vec(pend);

        wr_c0 = bus_we && (bus_addr == `MIC_OFS_CTRL0);
        wr_c1 = bus_we && (bus_addr == `MIC_OFS_CTRL1);
        wr_mf = bus_we && (bus_addr == `MIC_OFS_MFC);

        // Software writes first; service clears and event sets follow.
        if (wr_c0) begin
            s_next.c0 = bus_wdata & `MIC_MASK_CTRL0;
        end
        if (wr_c1) begin
            s_next.c1 = bus_wdata & `MIC_MASK_CTRL1;
        end
        if (wr_mf) begin
            s_next.mf = bus_wdata & `MIC_MASK_MFC;
        end
        if (bus_we && (bus_addr == `MIC_OFS_ESEL)) begin
            s_next.esel = bus_wdata & `MIC_MASK_ESEL;
        end

        if (bus_re) begin
            case (bus_addr)
                `MIC_OFS_CTRL0: s_next.rdata = s_reg.c0;
                `MIC_OFS_CTRL1: s_next.rdata = s_reg.c1;
                `MIC_OFS_MFC: s_next.rdata = s_reg.mf;
                `MIC_OFS_ESEL: s_next.rdata = s_reg.esel;
                default: s_next.rdata = 8'h00;
            endcase
        end

        case (s_reg.st)
            mic_pkg::MIC_IDLE: begin
                if (instr_en && s_reg.c0[`MIC_C0_GIE] && (|pend) && !stack_full) begin
                    s_next.st = mic_pkg::MIC_WAIT;
                    s_next.cnt = low_power ? `MIC_WAIT_WAKE : `MIC_WAIT_RUN;
                end
            end
            mic_pkg::MIC_WAIT: begin
                if (instr_en && (s_reg.cnt != 2'h0)) begin
                    s_next.cnt = s_reg.cnt - 2'h1;
                end else if (instr_en && !stack_full) begin
                    // The request is picked again here; one cleared meanwhile is dropped.
                    s_next.st = mic_pkg::MIC_IDLE;
                    if (s_reg.c0[`MIC_C0_GIE] && (|pend)) begin
                        s_next.core.vec_call = 1'b1;
                        s_next.core.pc_push = 1'b1;
                        s_next.core.vec_addr = fire_vec;
                        s_next.c0[`MIC_C0_GIE] = 1'b0;
                        case (fire_vec)
                            `MIC_VEC_PIN: s_next.c0[`MIC_C0_PINF] = 1'b0;
                            `MIC_VEC_T0: s_next.c0[`MIC_C0_T0F] = 1'b0;
                            `MIC_VEC_T1: s_next.c0[`MIC_C0_T1F] = 1'b0;
                            `MIC_VEC_TICK: s_next.c1[`MIC_C1_TBF] = 1'b0;
                            `MIC_VEC_MF: s_next.c1[`MIC_C1_MFF] = 1'b0;
                            default: s_next.c1 = s_next.c1;
                        endcase
                    end
                end
                // A full stack simply holds the count at zero until space frees up.
            end
            default: begin
                s_next.st = mic_pkg::MIC_IDLE;
            end
        endcase

        // Event sets come last so that they override any clear this cycle.
        if (pin_ev) begin
            s_next.c0[`MIC_C0_PINF] = 1'b1;
        end
        if (timer0_ovf) begin
            s_next.c0[`MIC_C0_T0F] = 1'b1;
        end
        if (timer1_ovf) begin
            s_next.c0[`MIC_C0_T1F] = 1'b1;
        end
        if (tick_ovf) begin
            s_next.c1[`MIC_C1_TBF] = 1'b1;
        end
        if (op0_ev) begin
            s_next.mf[`MIC_MF_A0F] = 1'b1;
        end
        if (op1_ev) begin
            s_next.mf[`MIC_MF_A1F] = 1'b1;
        end
        if (cmp_ev) begin
            s_next.mf[`MIC_MF_CF] = 1'b1;
        end
        // Only a sub-source whose own enable is set feeds the combined flag.
        if ((op0_ev && s_reg.mf[`MIC_MF_A0E]) || (op1_ev && s_reg.mf[`MIC_MF_A1E]) ||
            (cmp_ev && s_reg.mf[`MIC_MF_CE])) begin
            s_next.c1[`MIC_C1_MFF] = 1'b1;
        end

        // Wake ignores the master enable so a sleeping core can still resume.
        s_next.core.wake = |pend;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    property p_no_call_without_gie;
        vec_call |-> $past(s_reg.c0[`MIC_C0_GIE]);
    endproperty
    a_no_call_without_gie: assert property (p_no_call_without_gie)
        else $error("Vector taken while master enable was clear.");

    property p_call_clears_gie;
        vec_call |-> !s_reg.c0[`MIC_C0_GIE];
    endproperty
    a_call_clears_gie: assert property (p_call_clears_gie)
        else $error("Master enable still set after vectoring.");

    property p_timer0_sets;
        timer0_ovf |=> s_reg.c0[`MIC_C0_T0F];
    endproperty
    a_timer0_sets: assert property (p_timer0_sets)
        else $error("Timer 0 overflow did not set its flag.");

    property p_tick_sets;
        tick_ovf |=> s_reg.c1[`MIC_C1_TBF];
    endproperty
    a_tick_sets: assert property (p_tick_sets)
        else $error("Tick overflow did not set its flag.");

    property p_stack_blocks;
        vec_call |-> !$past(stack_full);
    endproperty
    a_stack_blocks: assert property (p_stack_blocks)
        else $error("Vector taken while the stack was full.");

    property p_push_with_call;
        (vec_call == pc_push);
    endproperty
    a_push_with_call: assert property (p_push_with_call)
        else $error("Program counter push and vector call disagree.");

    property p_pin_first;
        vec_call && $past(pend[0]) |-> vec_addr == `MIC_VEC_PIN;
    endproperty
    a_pin_first: assert property (p_pin_first)
        else $error("Pin request lost priority.");

    property p_mf_vector;
        vec_call && (vec_addr == `MIC_VEC_MF) |-> $past(pend) == 5'h10;
    endproperty
    a_mf_vector: assert property (p_mf_vector)
        else $error("Combined vector taken with a higher request pending.");

    property p_set_wins;
        timer1_ovf && bus_we && (bus_addr == `MIC_OFS_CTRL0) |=> s_reg.c0[`MIC_C0_T1F];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("Software clear beat a timer 1 overflow.");

    property p_flag_holds;
        $fell(s_reg.c0[`MIC_C0_T0F]) |-> $past(bus_we && (bus_addr == `MIC_OFS_CTRL0)) || vec_call;
    endproperty
    a_flag_holds: assert property (p_flag_holds)
        else $error("Timer 0 flag fell without a write or service.");

    property p_rise_sets_pin;
        (s_reg.esel[1:0] == `MIC_EDGE_RISE) && !s_reg.prev[0] && s_reg.sync2[0]
            |=> s_reg.c0[`MIC_C0_PINF];
    endproperty
    a_rise_sets_pin: assert property (p_rise_sets_pin)
        else $error("Rising pin edge did not set the pin flag.");

    property p_unused_zero;
        bus_re && (bus_addr == `MIC_OFS_CTRL1) |=> (bus_rdata & 8'h99) == 8'h00;
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("Unimplemented bits read as one.");

    c_pin_call: cover property (vec_call && (vec_addr == `MIC_VEC_PIN));
    c_mf_call: cover property (vec_call && (vec_addr == `MIC_VEC_MF));
    c_stack_stall: cover property ((s_reg.st == mic_pkg::MIC_WAIT) && stack_full && instr_en);
    c_wake_call: cover property (low_power && instr_en && (s_reg.st == mic_pkg::MIC_IDLE)
                                 ##[1:12] vec_call);

endmodule

`default_nettype wire

/* logic/mic_consts.svh */
`ifndef MIC_CONSTS_SVH
`define MIC_CONSTS_SVH
`define MIC_OFS_CTRL0 8'h00
`define MIC_OFS_CTRL1 8'h01
`define MIC_OFS_MFC 8'h02
`define MIC_OFS_ESEL 8'h03
`define MIC_MASK_CTRL0 8'h7f
`define MIC_MASK_CTRL1 8'h66
`define MIC_MASK_MFC 8'h77
`define MIC_MASK_ESEL 8'h03
`define MIC_RST_REG 8'h00
`define MIC_C0_T1F 6
`define MIC_C0_T0F 5
`define MIC_C0_PINF 4
`define MIC_C0_T1E 3
`define MIC_C0_T0E 2
`define MIC_C0_PINE 1
`define MIC_C0_GIE 0
`define MIC_C1_MFF 6
`define MIC_C1_TBF 5
`define MIC_C1_MFE 2
`define MIC_C1_TBE 1
`define MIC_MF_A1F 6
`define MIC_MF_A0F 5
`define MIC_MF_CF 4
`define MIC_MF_A1E 2
`define MIC_MF_A0E 1
`define MIC_MF_CE 0
`define MIC_IN_PIN 0
`define MIC_IN_OP0 1
`define MIC_IN_OP1 2
`define MIC_IN_CMP 3
`define MIC_EDGE_OFF 2'h0
`define MIC_EDGE_RISE 2'h1
`define MIC_EDGE_FALL 2'h2
`define MIC_EDGE_BOTH 2'h3
`define MIC_VEC_NONE 12'h000
`define MIC_VEC_PIN 12'h004
`define MIC_VEC_T0 12'h008
`define MIC_VEC_T1 12'h00c
`define MIC_VEC_TICK 12'h014
`define MIC_VEC_MF 12'h018
`define MIC_DIV_LAST 2'h3
`define MIC_WAIT_RUN 2'h1
`define MIC_WAIT_WAKE 2'h2
`endif

/* logic/mic_pkg.sv */
`default_nettype none
package mic_pkg;
    typedef enum logic {
        MIC_IDLE,
        MIC_WAIT
    } mic_st_e;

    typedef struct packed {
        logic vec_call;
        logic pc_push;
        logic [11:0] vec_addr;
        logic wake;
    } mic_core_s;

    typedef struct packed {
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [3:0] prev;
        logic [7:0] c0;
        logic [7:0] c1;
        logic [7:0] mf;
        logic [7:0] esel;
        logic [1:0] div;
        mic_st_e st;
        logic [1:0] cnt;
        logic [7:0] rdata;
        mic_core_s core;
    } mic_state_s;
endpackage
`default_nettype wire

/* dv/mic_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mic_core_model #(
    parameter int DEPTH = 2
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic vec_call,
    input wire logic pc_push,
    input wire logic ret_pulse,
    input wire logic sleep_cmd,
    output logic stack_full,
    output logic low_power,
    output logic [3:0] depth
);
    // Only the return address is stacked, so a level is one counter step.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            depth <= 4'h0;
            low_power <= 1'b0;
        end else begin
            if (vec_call && pc_push && !ret_pulse) begin
                depth <= depth + 4'h1;
            end else if (ret_pulse && !vec_call && depth != 4'h0) begin
                depth <= depth - 4'h1;
            end
            // A call ends any low-power stay.
            low_power <= sleep_cmd && !vec_call;
        end
    end
    assign stack_full = (depth == DEPTH[3:0]);
endmodule
`default_nettype wire

/* dv/mic_irq_ctrl_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mic_consts.svh"
module mic_irq_ctrl_bench;
    logic core_clk, rst, bus_we, bus_re, pin_irq_in, timer0_ovf, timer1_ovf, tick_ovf;
    logic opamp0_out, opamp1_out, comparator_out, ret_pulse, sleep_cmd;
    logic stack_full, low_power, vec_call, pc_push, wake_req;
    logic [7:0] bus_addr, bus_wdata, bus_rdata;
    logic [11:0] vec_addr;
    logic [3:0] depth;
    int mismatches = 0;
    int samples_checked = 0;
    int last_lat = 0;

    mic_irq_ctrl dut_u (.core_clk(core_clk), .rst(rst), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_we(bus_we), .bus_re(bus_re), .bus_rdata(bus_rdata),
        .pin_irq_in(pin_irq_in), .timer0_ovf(timer0_ovf), .timer1_ovf(timer1_ovf),
        .tick_ovf(tick_ovf), .opamp0_out(opamp0_out), .opamp1_out(opamp1_out),
        .comparator_out(comparator_out), .stack_full(stack_full), .low_power(low_power),
        .vec_call(vec_call), .pc_push(pc_push), .vec_addr(vec_addr), .wake_req(wake_req));
    mic_core_model #(.DEPTH(2)) core_u (.core_clk(core_clk), .rst(rst),
        .vec_call(vec_call), .pc_push(pc_push), .ret_pulse(ret_pulse),
        .sleep_cmd(sleep_cmd), .stack_full(stack_full), .low_power(low_power),
        .depth(depth));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_vec(input logic [11:0] got, input logic [11:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_we <= 1'b1;
        @(posedge core_clk);
        bus_we <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        bus_addr <= a;
        bus_re <= 1'b1;
        @(posedge core_clk);
        bus_re <= 1'b0;
        #1;
        chk_reg(bus_rdata, exp);
    endtask

    task automatic ret();
        @(posedge core_clk);
        ret_pulse <= 1'b1;
        @(posedge core_clk);
        ret_pulse <= 1'b0;
    endtask

    task automatic ovf0();
        @(posedge core_clk);
        timer0_ovf <= 1'b1;
        @(posedge core_clk);
        timer0_ovf <= 1'b0;
    endtask

    // The bound covers the longest tick-aligned latency with margin.
    task automatic wait_call(input logic [11:0] exp);
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (vec_call !== 1'b1 && n < 60);
        last_lat = n;
        if (n >= 60) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, vec_addr, exp);
            final_report();
        end else begin
            chk_vec(vec_addr, exp);
            chk_reg({7'h0, pc_push}, 8'h01);
        end
    endtask

    task automatic no_call();
        logic seen;
        seen = 1'b0;
        repeat (40) begin
            @(posedge core_clk);
            #1;
            if (vec_call !== 1'b0) seen = 1'b1;
        end
        chk_reg({7'h0, seen}, 8'h00);
    endtask

    task automatic t_regs();
        logic [7:0] wd [4] = '{8'hfe, 8'hff, 8'hff, 8'hff};
        logic [7:0] ms [4] = '{8'h7e, `MIC_MASK_CTRL1, `MIC_MASK_MFC, `MIC_MASK_ESEL};
        for (int i = 0; i < 4; i++) begin
            rd(i[7:0], `MIC_RST_REG);
            wr(i[7:0], wd[i]);
            rd(i[7:0], ms[i]);
            wr(i[7:0], 8'h00);
        end
        wr(8'h10, 8'hff);
        rd(8'h10, 8'h00);
        $display("test regs done");
    endtask

    task automatic t_prio();
        logic [11:0] v [5] = '{`MIC_VEC_PIN, `MIC_VEC_T0, `MIC_VEC_T1, `MIC_VEC_TICK, `MIC_VEC_MF};
        logic [7:0] c0;
        c0 = 8'h7e;
        wr(8'h01, 8'h66);
        for (int k = 0; k < 5; k++) begin
            wr(8'h00, c0 | 8'h01);
            wait_call(v[k]);
            // The request is written with an unknown tick phase, so two cycles span 9 to 12 clocks.
            if (k == 0) chk_reg({7'h0, (last_lat >= 9 && last_lat <= 12)}, 8'h01);
            ret();
            if (k < 3) c0 = c0 & ~(8'h10 << k);
            rd(8'h00, c0);
        end
        rd(8'h01, 8'h06);
        $display("test priority done");
    endtask

    task automatic t_mask();
        wr(8'h00, 8'h04);
        ovf0();
        no_call();
        rd(8'h00, 8'h24);
        chk_reg({7'h0, wake_req}, 8'h01);
        wr(8'h00, 8'h00);
        rd(8'h00, 8'h00);
        chk_reg({7'h0, wake_req}, 8'h00);
        $display("test mask done");
    endtask

    task automatic t_stack();
        repeat (2) begin
            wr(8'h00, 8'h05);
            ovf0();
            wait_call(`MIC_VEC_T0);
        end
        wr(8'h00, 8'h05);
        ovf0();
        no_call();
        ret();
        wait_call(`MIC_VEC_T0);
        repeat (2) ret();
        $display("test stack done");
    endtask

    task automatic t_comb();
        wr(8'h02, 8'h03);
        wr(8'h01, 8'h04);
        @(posedge core_clk);
        comparator_out <= 1'b1;
        opamp0_out <= 1'b0;
        repeat (8) @(posedge core_clk);
        rd(8'h02, 8'h33);
        rd(8'h01, 8'h44);
        wr(8'h00, 8'h01);
        wait_call(`MIC_VEC_MF);
        ret();
        rd(8'h01, 8'h04);
        rd(8'h02, 8'h33);
        $display("test combined done");
    endtask

    task automatic pin_step(input logic [1:0] mode, input logic lvl, input logic [7:0] exp);
        wr(8'h00, 8'h00);
        wr(8'h03, {6'h00, mode});
        @(posedge core_clk);
        pin_irq_in <= lvl;
        repeat (8) @(posedge core_clk);
        rd(8'h00, exp);
    endtask

    task automatic t_pin();
        wr(8'h02, 8'h00);
        pin_step(`MIC_EDGE_FALL, 1'b1, 8'h00);
        pin_step(`MIC_EDGE_FALL, 1'b0, 8'h10);
        pin_step(`MIC_EDGE_RISE, 1'b1, 8'h10);
        pin_step(`MIC_EDGE_BOTH, 1'b0, 8'h10);
        pin_step(`MIC_EDGE_OFF, 1'b1, 8'h00);
        $display("test pin done");
    endtask

    // A sleeping core adds one instruction cycle, so the call lands 13 to 16 clocks on.
    task automatic t_wake();
        @(posedge core_clk);
        sleep_cmd <= 1'b1;
        wr(8'h00, 8'h04);
        ovf0();
        wr(8'h00, 8'h25);
        wait_call(`MIC_VEC_T0);
        chk_reg({7'h0, (last_lat >= 13 && last_lat <= 16)}, 8'h01);
        ret();
        sleep_cmd <= 1'b0;
        rd(8'h00, 8'h04);
        $display("test wake done");
    endtask

    initial begin
        rst = 1'b1;
        {bus_we, bus_re, pin_irq_in, timer0_ovf, timer1_ovf, tick_ovf} = 6'h00;
        {opamp1_out, comparator_out, ret_pulse, sleep_cmd} = 4'h0;
        opamp0_out = 1'b1;
        bus_addr = 8'h00;
        bus_wdata = 8'h00;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        t_regs();
        t_prio();
        t_mask();
        t_stack();
        t_comb();
        t_pin();
        t_wake();
        final_report();
    end
endmodule
`default_nettype wire
